// ===== verification/lcc_host_model.sv
// Two-wire host model that configures the compensation bank
`timescale 1ns/10ps
`include "lcc_params.svh"
module lcc_host_model (
   input  wire logic mclk,     // System clock
   input  wire logic sdaLine,  // Resolved data line level
   output logic      scl,      // Serial clock, idles high
   output logic      sdaLow    // High while the host pulls data low
);
   localparam int HALF = 10;   // Serial clock high time in mclk cycles; a bit lasts 4 + 2 * HALF

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Also serves as repeated start; data falls while the clock is high
   task automatic start_cond();
      wait_clk(4);
      sdaLow = 1'b0;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      sdaLow = 1'b1;
      wait_clk(HALF);
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      wait_clk(4);
      sdaLow = 1'b1;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      sdaLow = 1'b0;
      wait_clk(HALF);
   endtask

   task automatic xfer_bit(input logic b, output logic seen);
      wait_clk(4);
      sdaLow = ~b;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      seen = sdaLine;
      scl = 1'b0;
   endtask

   // Returns 1 when the device acknowledged the byte
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], s);
      end
      xfer_bit(1'b1, s);
      ack = ~s;
   endtask

   task automatic recv_byte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, s);
         d[i] = s;
      end
      xfer_bit(1'b1, s);   // Not acknowledged: the read ends here
   endtask

   task automatic write_reg(input logic [6:0] a, input logic [7:0] c, d,
                            input logic extra, output logic [3:0] acks);
      logic [7:0] v;
      v = d;
      if (c == `LCC_ALT_CMD && v[7:4] > 4'hb) begin
         v[7:4] = 4'hb;
      end
      acks = 4'h0;
      start_cond();
      send_byte({a, 1'b0}, acks[3]);
      send_byte(c, acks[2]);
      send_byte(v, acks[1]);
      if (extra) begin
         send_byte(~v, acks[0]);
      end
      stop_cond();
   endtask

   task automatic read_reg(input logic [7:0] c, output logic [7:0] d,
                           output logic [2:0] acks);
      start_cond();
      send_byte({`LCC_DEV_ADDR, 1'b0}, acks[2]);
      send_byte(c, acks[1]);
      start_cond();
      send_byte({`LCC_DEV_ADDR, 1'b1}, acks[0]);
      recv_byte(d);
      stop_cond();
   endtask
endmodule // lcc_host_model

// ===== verification/lcc_loop_comp_cfg_test.sv
// Self-checking bench of the loop compensation configuration block
`timescale 1ns/10ps
`include "lcc_params.svh"
module lcc_loop_comp_cfg_test;
   import lcc_pkg::*;
   logic       mclk, resetn, scl, sdaLow, sdaLine, sdaOut, sdaOe;
   lcc_byte_t  nvmMain, nvmAlt;
   lcc_gain_t  intGain;
   lcc_time_t  intTime;
   lcc_ramp_t  rampAmp;
   int         badCount, comparisons;
   logic [7:0] gainExp [0:3] = '{8'h04, 8'h03, 8'h02, 8'h01};
   logic [7:0] timeExp [0:7] = '{8'h01, 8'h04, 8'h0c, 8'h12,
                                 8'h19, 8'h20, 8'h28, 8'h50};
   logic [7:0] rampExp [0:7] = '{8'h28, 8'h3c, 8'h50, 8'h64,
                                 8'h78, 8'ha0, 8'hc8, 8'hf0};

   // Open-drain data line with pull-up
   assign sdaLine = ~(sdaOe | sdaLow);

   lcc_loop_comp_cfg dut (.mclk(mclk), .resetn(resetn), .scl(scl),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .nvmMain(nvmMain),
      .nvmAlt(nvmAlt), .intGain(intGain), .intTime(intTime),
      .rampAmp(rampAmp));

   lcc_host_model host (.mclk(mclk), .sdaLine(sdaLine), .scl(scl),
      .sdaLow(sdaLow));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic giveVerdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check_decode(input logic [7:0] v);
      check({5'h00, intGain}, gainExp[v[7:6]]);
      check({1'b0, intTime}, timeExp[v[5:3]]);
      check(rampAmp, rampExp[v[2:0]]);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset with given stored defaults, then outputs and read-back
   task automatic t_defaults(input logic [7:0] m, a);
      logic [7:0] d;
      logic [2:0] acks;
      @(negedge mclk);
      nvmMain = m;
      nvmAlt = a;
      resetn = 1'b0;
      repeat (12) @(negedge mclk);
      resetn = 1'b1;
      repeat (20) @(negedge mclk);
      check_decode(m);
      check({7'h00, sdaOut}, 8'h00);
      host.read_reg(`LCC_MAIN_CMD, d, acks);
      check(d, m);
      check({5'h00, acks}, 8'h07);
      host.read_reg(`LCC_ALT_CMD, d, acks);
      check(d, a);
      $display("t_defaults done");
   endtask

   // Every gain, time and ramp code, acting as soon as written
   task automatic t_main_codes();
      logic [7:0] v, d;
      logic [3:0] acks;
      logic [2:0] racks;
      for (int i = 0; i < 8; i++) begin
         v = {2'(i), 3'(i), 3'(7 - i)};
         host.write_reg(`LCC_DEV_ADDR, `LCC_MAIN_CMD, v, 1'b0, acks);
         check({4'h0, acks}, 8'h0e);
         check_decode(v);
         host.read_reg(`LCC_MAIN_CMD, d, racks);
         check(d, v);
      end
      $display("t_main_codes done");
   endtask

   // Spare register stores all legal codes and steers nothing
   task automatic t_spare();
      logic [7:0] v, d, m;
      logic [3:0] acks;
      logic [2:0] racks;
      m = 8'hc6;
      host.write_reg(`LCC_DEV_ADDR, `LCC_MAIN_CMD, m, 1'b0, acks);
      for (int i = 0; i < 16; i++) begin
         v = {4'(i % 12), 4'(i)};
         host.write_reg(`LCC_DEV_ADDR, `LCC_ALT_CMD, v, 1'b0, acks);
         check({4'h0, acks}, 8'h0e);
         check_decode(m);
         host.read_reg(`LCC_ALT_CMD, d, racks);
         check(d[7:4], v[7:4]);
         check(d[3:0], v[3:0]);
         check(d, v);
      end
      $display("t_spare done");
   endtask

   // Foreign address, unknown command and a second data byte
   task automatic t_refused();
      logic [7:0] d;
      logic [3:0] acks;
      logic [2:0] racks;
      host.write_reg(`LCC_DEV_ADDR, `LCC_MAIN_CMD, 8'h92, 1'b1, acks);
      check({4'h0, acks}, 8'h0e);
      host.write_reg(`LCC_DEV_ADDR ^ 7'h01, `LCC_MAIN_CMD, 8'h00, 1'b0, acks);
      check({4'h0, acks}, 8'h00);
      host.write_reg(`LCC_DEV_ADDR, 8'hac, 8'h00, 1'b0, acks);
      check({4'h0, acks}, 8'h08);
      // Unmapped command: refused, then reads back as zero
      host.read_reg(8'hac, d, racks);
      check({5'h00, racks}, 8'h05);
      check(d, 8'h00);
      host.read_reg(`LCC_MAIN_CMD, d, racks);
      check(d, 8'h92);
      check_decode(8'h92);
      $display("t_refused done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      nvmMain = 8'h5b;
      nvmAlt = 8'hc7;
      badCount = 0;
      comparisons = 0;
      t_defaults(8'h5b, 8'hc7);
      t_main_codes();
      t_spare();
      t_refused();
      t_defaults(8'h2d, 8'h96);
      giveVerdict();
   end

   initial begin
      repeat (100000) @(posedge mclk);
      badCount++;
      $display("BAD at %0t: run did not end, seen %h expected %h",
               $time, 1'b0, 1'b1);
      giveVerdict();
   end
endmodule // lcc_loop_comp_cfg_test

// ===== verilog/lcc_cfg_if.sv
// Register access path between the serial slave and the register bank
`timescale 1ns/10ps
interface lcc_cfg_if;
   logic       wrEn;    // One-cycle write strobe
   logic [7:0] cmd;     // Selected command code
   logic [7:0] wdata;   // Write data
   logic [7:0] rdata;   // Read data of the selected register

   modport master (output wrEn, output cmd, output wdata, input rdata);
   modport bank   (input wrEn, input cmd, input wdata, output rdata);
endinterface

// ===== verilog/lcc_comp_bank.sv
// Compensation registers with nonvolatile defaults and field decode
`timescale 1ns/10ps
`include "lcc_params.svh"
module lcc_comp_bank (
   input  wire logic            mclk,     // System clock
   input  wire logic            rstn,     // Synchronised reset, active low
   input  wire logic            nvmLoad,  // Load defaults, one cycle
   input  wire lcc_pkg::lcc_byte_t nvmMain, // Stored main default
   input  wire lcc_pkg::lcc_byte_t nvmAlt,  // Stored spare default
   lcc_cfg_if.bank              bus,      // Register access
   output lcc_pkg::lcc_gain_t   intGain,  // Decoded integrator gain
   output lcc_pkg::lcc_time_t   intTime,  // Decoded integrator time
   output lcc_pkg::lcc_ramp_t   rampAmp   // Decoded ramp amplitude
);
   import lcc_pkg::*;

   lcc_byte_t mainReg;
   lcc_byte_t altReg;
   logic [1:0] gainF;
   logic [2:0] timeF;
   logic [2:0] rampF;
   logic [3:0] sGainF;
   logic [3:0] sDroopF;

   assign gainF   = mainReg[`LCC_GAIN_MSB:`LCC_GAIN_LSB];     // see [RQ10]
   assign timeF   = mainReg[`LCC_TIME_MSB:`LCC_TIME_LSB];
   assign rampF   = mainReg[`LCC_RAMP_MSB:`LCC_RAMP_LSB];
   assign sGainF  = altReg[`LCC_SGAIN_MSB:`LCC_SGAIN_LSB];    // see [RQ4]
   assign sDroopF = altReg[`LCC_SDROOP_MSB:`LCC_SDROOP_LSB];  // see [RQ6]

   ////////////////////////////////////////////////////////////////////////
   // Registers: defaults first, then host writes take effect at once
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mainReg <= `LCC_MAIN_RST;
      end else if (nvmLoad) begin
         mainReg <= nvmMain;                                  // see [RQ11]
      end else if (bus.wrEn && bus.cmd == `LCC_MAIN_CMD) begin
         mainReg <= bus.wdata;                                // see [RQ11]
      end
   end

   // Reserved spare gain codes are stored as written
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         altReg <= `LCC_ALT_RST;
      end else if (nvmLoad) begin
         altReg <= nvmAlt;                                    // see [RQ11]
      end else if (bus.wrEn && bus.cmd == `LCC_ALT_CMD) begin
         altReg <= bus.wdata;                                 // see [RQ9]
      end
   end

   always_comb begin
      case (bus.cmd)
         `LCC_MAIN_CMD: bus.rdata = mainReg;
         `LCC_ALT_CMD:  bus.rdata = {sGainF, sDroopF};        // see [RQ7]
         default:       bus.rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode; only the main register feeds the loop
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         intGain <= 3'h0;
         intTime <= 7'h00;
         rampAmp <= 8'h00;
      end else begin
         intGain <= LCC_GAIN_LUT[gainF];                      // see [RQ1]
         intTime <= LCC_TIME_LUT[timeF];                      // see [RQ2]
         rampAmp <= LCC_RAMP_LUT[rampF];                      // see [RQ3]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence sMainWrite;
      bus.wrEn && bus.cmd == `LCC_MAIN_CMD && !nvmLoad;
   endsequence
   sequence sAltWrite;
      bus.wrEn && bus.cmd == `LCC_ALT_CMD && !nvmLoad;
   endsequence

   a_gain_decode: assert property (sMainWrite |=> ##1                // see [RQ1]
      mainReg == $past(bus.wdata, 2) && intGain == LCC_GAIN_LUT[gainF])
      else $error("integrator gain does not follow main write");
   a_time_decode: assert property ($changed(timeF) |=>              // see [RQ2]
      intTime == LCC_TIME_LUT[$past(timeF)])
      else $error("integrator time decode wrong");
   a_ramp_decode: assert property ($stable(rampF) [*2] |->          // see [RQ3]
      rampAmp == LCC_RAMP_LUT[rampF])
      else $error("ramp amplitude decode wrong");
   a_spare_store: assert property (sAltWrite ##1                    // see [RQ9]
      bus.cmd == `LCC_ALT_CMD |-> bus.rdata == $past(bus.wdata))
      else $error("spare register does not read back");
   a_spare_fields: assert property (sAltWrite |=>                   // see [RQ4]
      sGainF == $past(bus.wdata[7:4]) && sDroopF == $past(bus.wdata[3:0]))
      else $error("spare fields misplaced");
   a_spare_inert: assert property (sAltWrite |=>                    // see [RQ7]
      ($stable(intGain) && $stable(intTime) && $stable(rampAmp)) [*2])
      else $error("spare register changed loop settings");
   a_nvm_default: assert property (nvmLoad |=>                      // see [RQ11]
      mainReg == $past(nvmMain) && altReg == $past(nvmAlt))
      else $error("defaults not loaded");

endmodule // lcc_comp_bank

// ===== verilog/lcc_loop_comp_cfg.sv
// Loop compensation configuration: serial slave and register bank
// Function
// [RQ1] Integrator gain codes 0..3 in bits 7:6 give gains 2, 1.5, 1, 0.5.
// [RQ2] Integrator time codes in bits 5:3 give 0.25 to 20 us ascending.
// [RQ3] Ramp codes in bits 2:0 give 40 to 240 mV ascending.
// [RQ4] The spare register keeps a four-bit transient gain in bits 7:4.
// [RQ5] The host never writes gain codes 12 to 15, which are reserved.
// [RQ6] The spare register keeps a four-bit transient droop in bits 3:0.
// [RQ7] The spare register reads back but steers nothing.
// [RQ8] The spare register uses one-byte write and read transactions.
// [RQ9] The spare register is one plain byte, every bit read and write.
// [RQ10] The main register holds exactly the three loop fields.
// [RQ11] Defaults load from storage at reset; writes act at once.
`timescale 1ns/10ps
`include "lcc_params.svh"
module lcc_loop_comp_cfg (
   input  wire logic               mclk,    // System clock, 125 MHz
   input  wire logic               resetn,  // Asynchronous reset, low
   input  wire logic               scl,     // Serial clock pin
   input  wire logic               sdaIn,   // Serial data pin level
   output logic                    sdaOut,  // Serial data drive value
   output logic                    sdaOe,   // Serial data pulled low
   input  wire lcc_pkg::lcc_byte_t nvmMain, // Stored main default
   input  wire lcc_pkg::lcc_byte_t nvmAlt,  // Stored spare default
   output lcc_pkg::lcc_gain_t      intGain, // Integrator gain, 0.5 steps
   output lcc_pkg::lcc_time_t      intTime, // Integrator time, 0.25 us
   output lcc_pkg::lcc_ramp_t      rampAmp  // Ramp amplitude, mV
);
   import lcc_pkg::*;

   logic [1:0] rstSync;
   logic       rstn;
   logic       loaded;
   logic       nvmLoad;
   wire  [1:0] pinRaw;
   wire  [1:0] pinF;
   logic       sclF;
   logic       sdaF;
   logic       sclPrev;
   logic       sdaPrev;
   logic       sclRise;
   logic       sclFall;
   logic       start;
   logic       stop;
   lcc_state_t state;
   logic       isRead;
   logic [1:0] byteIdx;
   logic [3:0] bitCnt;
   lcc_byte_t  rxByte;
   lcc_byte_t  txShift;
   lcc_byte_t  cmd;
   logic       addrHit;
   logic       rxKnown;
   logic       cmdKnown;
   logic       byteAck;
   logic       rdMsb;

   lcc_cfg_if cfg ();

   ////////////////////////////////////////////////////////////////////////
   // Reset release and one default load after it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstn = rstSync[1];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         loaded  <= 1'b0;
         nvmLoad <= 1'b0;
      end else begin
         nvmLoad <= ~loaded;                                  // see [RQ11]
         loaded  <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; a level counts once stages two and three agree
   assign pinRaw = {scl, sdaIn};

   for (genvar i = 0; i < 2; i++) begin : gSync
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            s1   <= 1'b1;
            s2   <= 1'b1;
            s3   <= 1'b1;
            filt <= 1'b1;
         end else begin
            s1 <= pinRaw[i];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
               filt <= s3;
            end
         end
      end
      assign pinF[i] = filt;
   end

   assign sclF = pinF[1];
   assign sdaF = pinF[0];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclF;
         sdaPrev <= sdaF;
      end
   end

   assign sclRise = sclF & ~sclPrev;
   assign sclFall = ~sclF & sclPrev;
   assign start   = sclF & sclPrev & sdaPrev & ~sdaF;
   assign stop    = sclF & sclPrev & ~sdaPrev & sdaF;

   assign addrHit  = rxByte[7:1] == `LCC_DEV_ADDR;
   assign rxKnown  = rxByte == `LCC_MAIN_CMD || rxByte == `LCC_ALT_CMD;
   assign cmdKnown = cmd == `LCC_MAIN_CMD || cmd == `LCC_ALT_CMD;
   // Command byte, then one data byte; anything further is refused
   assign byteAck  = (byteIdx == 2'h0) ? rxKnown :
                     (byteIdx == 2'h1) && cmdKnown;           // see [RQ8]
   assign rdMsb    = cfg.rdata[7];

   ////////////////////////////////////////////////////////////////////////
   // Transaction sequencing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state   <= LCC_IDLE;
         isRead  <= 1'b0;
         byteIdx <= 2'h0;
         cmd     <= 8'h00;
      end else if (stop) begin
         state <= LCC_IDLE;
      end else if (start) begin
         state   <= LCC_ADDR;
         byteIdx <= 2'h0;
      end else if (sclFall) begin
         case (state)
            LCC_ADDR: begin
               if (bitCnt == `LCC_BYTE_BITS) begin
                  if (addrHit) begin
                     state  <= LCC_ACK;
                     isRead <= rxByte[0];
                  end else begin
                     state <= LCC_IDLE;
                  end
               end
            end
            LCC_WRBYTE: begin
               if (bitCnt == `LCC_BYTE_BITS) begin
                  state <= byteAck ? LCC_ACK : LCC_IDLE;
                  if (byteIdx == 2'h0) begin
                     cmd <= rxByte;
                  end
                  if (byteIdx != 2'h2) begin
                     byteIdx <= byteIdx + 2'h1;
                  end
               end
            end
            LCC_ACK: begin
               state <= isRead ? LCC_RDBYTE : LCC_WRBYTE;    // see [RQ8]
            end
            LCC_RDBYTE: begin
               if (bitCnt == `LCC_LAST_RD_BIT) begin
                  state <= LCC_RACK;
               end
            end
            default: begin
               state <= LCC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit counting and receive shifting
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bitCnt <= 4'h0;
         rxByte <= 8'h00;
      end else if (start || stop) begin
         bitCnt <= 4'h0;
      end else if (sclRise && (state == LCC_ADDR || state == LCC_WRBYTE)
                   && bitCnt != `LCC_BYTE_BITS) begin
         rxByte <= {rxByte[6:0], sdaF};
         bitCnt <= bitCnt + 4'h1;
      end else if (sclFall && state == LCC_ACK) begin
         bitCnt <= 4'h0;
      end else if (sclFall && state == LCC_RDBYTE) begin
         bitCnt <= bitCnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data line drive: acknowledge and read bits, changed on falls, released at start and stop
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sdaOe   <= 1'b0;
         sdaOut  <= 1'b0;
         txShift <= 8'h00;
      end else if (start || stop) begin
         sdaOe <= 1'b0;
      end else if (sclFall) begin
         case (state)
            LCC_ADDR: begin
               sdaOe <= bitCnt == `LCC_BYTE_BITS && addrHit;
            end
            LCC_WRBYTE: begin
               sdaOe <= bitCnt == `LCC_BYTE_BITS && byteAck;
            end
            LCC_ACK: begin
               if (isRead) begin
                  sdaOe   <= ~rdMsb;                          // see [RQ8]
                  txShift <= {cfg.rdata[6:0], 1'b0};
               end else begin
                  sdaOe <= 1'b0;
               end
            end
            LCC_RDBYTE: begin
               if (bitCnt == `LCC_LAST_RD_BIT) begin
                  sdaOe <= 1'b0;
               end else begin
                  sdaOe   <= ~txShift[7];
                  txShift <= {txShift[6:0], 1'b0};
               end
            end
            default: begin
               sdaOe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write strobe after the single data byte
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg.wrEn  <= 1'b0;
         cfg.wdata <= 8'h00;
      end else begin
         cfg.wrEn  <= sclFall && !start && !stop && state == LCC_WRBYTE
                      && bitCnt == `LCC_BYTE_BITS && byteIdx == 2'h1
                      && cmdKnown;                            // see [RQ8]
         cfg.wdata <= rxByte;
      end
   end
   assign cfg.cmd = cmd;

   lcc_comp_bank uBank (
      .mclk    (mclk),
      .rstn    (rstn),
      .nvmLoad (nvmLoad),
      .nvmMain (nvmMain),
      .nvmAlt  (nvmAlt),
      .bus     (cfg.bank),
      .intGain (intGain),
      .intTime (intTime),
      .rampAmp (rampAmp)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence sDataByte;
      sclFall && !start && !stop && state == LCC_WRBYTE
         && bitCnt == `LCC_BYTE_BITS && byteIdx == 2'h1 && cmdKnown;
   endsequence

   a_write_strobe: assert property (sDataByte |=>                   // see [RQ8]
      cfg.wrEn && cfg.wdata == $past(rxByte) && byteIdx == 2'h2)
      else $error("data byte did not write");
   a_single_write: assert property (cfg.wrEn |=>                    // see [RQ8]
      !cfg.wrEn [*2])
      else $error("more than one write per transaction");
   a_read_first: assert property (sclFall && !start && !stop        // see [RQ8]
      && state == LCC_ACK && isRead |=> sdaOe == !$past(rdMsb))
      else $error("first read bit wrong");
   // Gain output lags the register by one cycle
   a_main_fields: assert property (cfg.cmd == `LCC_MAIN_CMD |=> // see [RQ10]
      intGain == LCC_GAIN_LUT[$past(cfg.rdata[`LCC_GAIN_MSB:`LCC_GAIN_LSB])])
      else $error("main register does not match its gain field");

endmodule // lcc_loop_comp_cfg

// ===== verilog/lcc_params.svh
// Offsets, field positions, reset values and counts of the compensation bank
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// Bus address of the device; the value is arbitrary
`define LCC_DEV_ADDR     7'h2c

`define LCC_MAIN_CMD     8'haa
`define LCC_ALT_CMD      8'hab

`define LCC_GAIN_MSB     7
`define LCC_GAIN_LSB     6
`define LCC_TIME_MSB     5
`define LCC_TIME_LSB     3
`define LCC_RAMP_MSB     2
`define LCC_RAMP_LSB     0
`define LCC_SGAIN_MSB    7
`define LCC_SGAIN_LSB    4
`define LCC_SDROOP_MSB   3
`define LCC_SDROOP_LSB   0

`define LCC_MAIN_RST     8'h00
`define LCC_ALT_RST      8'h00

`define LCC_BYTE_BITS    4'h8
`define LCC_LAST_RD_BIT  4'h7

`endif

// ===== verilog/lcc_pkg.sv
// Types and decode tables of the loop compensation bank
package lcc_pkg;

   typedef logic [7:0] lcc_byte_t;
   typedef logic [2:0] lcc_gain_t;   // Integrator gain in steps of 0.5
   typedef logic [6:0] lcc_time_t;   // Integrator time in steps of 0.25 us
   typedef logic [7:0] lcc_ramp_t;   // Ramp amplitude in mV

   typedef enum logic [2:0] {
      LCC_IDLE   = 3'b000,
      LCC_ADDR   = 3'b001,
      LCC_ACK    = 3'b010,
      LCC_WRBYTE = 3'b011,
      LCC_RDBYTE = 3'b100,
      LCC_RACK   = 3'b101
   } lcc_state_t;

   // Gains 2, 1.5, 1, 0.5
   localparam lcc_gain_t LCC_GAIN_LUT [0:3] = '{3'h4, 3'h3, 3'h2, 3'h1};
   // 0.25, 1.0, 3.0, 4.5, 6.25, 8.0, 10.0, 20.0 us
   localparam lcc_time_t LCC_TIME_LUT [0:7] = '{7'h01, 7'h04, 7'h0c, 7'h12,
                                                7'h19, 7'h20, 7'h28, 7'h50};
   // 40, 60, 80, 100, 120, 160, 200, 240 mV
   localparam lcc_ramp_t LCC_RAMP_LUT [0:7] = '{8'h28, 8'h3c, 8'h50, 8'h64,
                                                8'h78, 8'ha0, 8'hc8, 8'hf0};

endpackage
